// ### hdl/assi_pkg.sv
// Package for the sequence input select block: register map, fields and states
package assi_pkg;
  localparam logic [7:0] SEL_OFFSET = 8'h00;
  localparam logic [7:0] CTL_OFFSET = 8'h04;
  localparam logic [7:0] STAT_OFFSET = 8'h08;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  // Writable selection bits: 1:0, 5:4, ... 29:28; gaps are read-only zero
  localparam logic [31:0] SEL_WMASK = 32'h3333_3333;
  localparam int FIELD_STRIDE = 4;
  localparam int NUM_SAMPLES = 8;
  localparam logic [2:0] LAST_POS = 3'h7;
  // Control register: end flags in 7:0, differential flags in 15:8
  localparam int CTL_END_LSB = 0;
  localparam int CTL_DIFF_LSB = 8;
  localparam logic [31:0] CTL_WMASK = 32'h0000_FFFF;
  // Status: bit 0 busy, bits 6:4 current position
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_POS_LSB = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } assi_state_e;

  typedef struct packed {
    logic valid;
    logic diff;
    logic [2:0] pos;
    logic [1:0] sel;
    logic [3:0] pin_p;
    logic [3:0] pin_n;
  } assi_conv_req_s;
endpackage

// ### hdl/assi_top.sv
// Sequence input select register with Wishbone slave and sample stepping
`timescale 1ns/1ps
`default_nettype none
module assi_top
  import assi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic seq_start_i,
  input wire logic conv_done_i,
  output assi_conv_req_s conv_req_o,
  output logic seq_done_o
);

  // Writable part of one register: byte lanes enabled by sel, limited to the mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel, input logic [31:0] wm);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = {8{sel[b]}};
    end
    lane_mask = m & wm;
  endfunction

  // New write data where the mask is set, old contents everywhere else
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [31:0] m);
    lane_merge = (old & ~m) | (nw & m);
  endfunction

  // Lowest bit of the selection field of sample position n
  function automatic logic [4:0] field_lsb(input logic [2:0] n);
    field_lsb = 5'(FIELD_STRIDE * int'(n));
  endfunction

  // Two-bit selection field of sample position n
  function automatic logic [1:0] field_at(input logic [31:0] r, input logic [2:0] n);
    field_at = r[field_lsb(n) +: 2];
  endfunction

  // Per-position flag out of an eight-bit flag group
  function automatic logic flag_at(input logic [7:0] flags, input logic [2:0] n);
    flag_at = flags[n];
  endfunction

  // Readback rebuilt field by field so every gap reads as constant zero
  function automatic logic [31:0] pack_fields(input logic [7:0][1:0] f);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int n = 0; n < NUM_SAMPLES; n++) begin
      w[FIELD_STRIDE*n +: 2] = f[n];
    end
    pack_fields = w;
  endfunction

  // Positive pin: the field itself, or the even pin 2i of pair i
  function automatic logic [3:0] pin_pos(input logic [1:0] f, input logic diff);
    pin_pos = diff ? {1'b0, f, 1'b0} : {2'b00, f};
  endfunction

  // Negative pin: odd pin 2i+1 of pair i, zero when single-ended
  function automatic logic [3:0] pin_neg(input logic [1:0] f, input logic diff);
    pin_neg = diff ? {1'b0, f, 1'b1} : 4'h0;
  endfunction

  // Status word: busy flag and current position, all other bits zero
  function automatic logic [31:0] status_word(input logic bsy, input logic [2:0] n);
    logic [31:0] s;
    s = 32'h0000_0000;
    s[STAT_BUSY_BIT] = bsy;
    s[STAT_POS_LSB +: 3] = n;
    status_word = s;
  endfunction

  // Next sample position; the end test stops the walk before it could wrap
  function automatic logic [2:0] next_pos(input logic [2:0] n);
    next_pos = n + 3'h1;
  endfunction

  logic [31:0] sel_q;
  logic [31:0] sel_d;
  logic [31:0] ctl_q;
  logic [31:0] ctl_d;
  logic [31:0] rdat_q;
  logic ack_q;
  assi_state_e state_q;
  assi_state_e state_d;
  logic [2:0] pos_q;
  logic [2:0] pos_d;
  assi_conv_req_s req_q;
  assi_conv_req_s req_d;
  logic done_q;
  logic [1:0] cur_sel;

  // Handshake: the request is taken on the edge where it is first seen without ack;
  // read data is captured there and ack stands for the single following cycle.
  // The write itself lands on the next edge, the one at which the master sees ack,
  // so a master that gives up before ack leaves the registers untouched.
  wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  wire logic hit_sel = (wb_adr_i == SEL_OFFSET);
  wire logic hit_ctl = (wb_adr_i == CTL_OFFSET);
  wire logic hit_stat = (wb_adr_i == STAT_OFFSET);
  wire logic wr_sel = bus_wr & hit_sel;
  wire logic wr_ctl = bus_wr & hit_ctl;
  // Gap bits never enter the write mask, so they stay at their zero reset
  wire logic [31:0] sel_wr_mask = lane_mask(wb_sel_i, SEL_WMASK);
  wire logic [31:0] ctl_wr_mask = lane_mask(wb_sel_i, CTL_WMASK);

  assign sel_d = wr_sel ? lane_merge(sel_q, wb_dat_i, sel_wr_mask) : sel_q;
  assign ctl_d = wr_ctl ? lane_merge(ctl_q, wb_dat_i, ctl_wr_mask) : ctl_q;

  // Named views of the selection fields, one per sample position
  wire logic [1:0] first_sample_input_sel = field_at(sel_q, 3'h0);
  wire logic [1:0] second_sample_input_sel = field_at(sel_q, 3'h1);
  wire logic [1:0] third_sample_input_sel = field_at(sel_q, 3'h2);
  wire logic [1:0] fourth_sample_input_sel = field_at(sel_q, 3'h3);
  wire logic [1:0] fifth_sample_input_sel = field_at(sel_q, 3'h4);
  wire logic [1:0] sixth_sample_input_sel = field_at(sel_q, 3'h5);
  wire logic [1:0] seventh_sample_input_sel = field_at(sel_q, 3'h6);
  wire logic [1:0] eighth_sample_input_sel = field_at(sel_q, 3'h7);
  // Highest position first, so that element n is the field of position n
  wire logic [7:0][1:0] field_vec = {eighth_sample_input_sel, seventh_sample_input_sel,
    sixth_sample_input_sel, fifth_sample_input_sel, fourth_sample_input_sel,
    third_sample_input_sel, second_sample_input_sel, first_sample_input_sel};

  // Per-position end and differential flags
  wire logic [7:0] end_flags = ctl_q[CTL_END_LSB +: NUM_SAMPLES];
  wire logic [7:0] differential_sample_flag = ctl_q[CTL_DIFF_LSB +: NUM_SAMPLES];

  // Sequencer status; a start while busy and a done while idle are both ignored
  wire logic busy = (state_q == ST_CONV);
  wire logic start_ok = seq_start_i & ~busy;
  wire logic step_ok = busy & conv_done_i & req_q.valid;
  wire logic cur_end = flag_at(end_flags, pos_q);
  wire logic at_last = (pos_q == LAST_POS);
  // A set end flag stops the walk; later fields are never requested
  wire logic seq_end = cur_end | at_last;

  // Readback values of the three mapped words
  wire logic [31:0] sel_rd = pack_fields(field_vec);
  wire logic [31:0] ctl_rd = ctl_q & CTL_WMASK;
  wire logic [31:0] stat_rd = status_word(busy, pos_q);
  // Unmapped addresses are acked with zero data rather than stalling the bus
  wire logic [31:0] rdat_d = hit_sel ? sel_rd
                           : hit_ctl ? ctl_rd
                           : hit_stat ? stat_rd
                           : 32'h0000_0000;

  // Sequencer: idle until started, then one position per finished conversion
  always_comb begin
    state_d = state_q;
    pos_d = pos_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_ok) begin
          pos_d = 3'h0;
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (step_ok) begin
          if (seq_end) begin
            state_d = ST_IDLE;
          end else begin
            pos_d = next_pos(pos_q);
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        pos_d = 3'h0;
      end
    endcase
  end

  // Field of the position about to be requested; it follows pos_d so the request
  // and its field change on the same edge
  always_comb begin
    cur_sel = first_sample_input_sel;
    unique case (pos_d)
      3'h0: cur_sel = first_sample_input_sel;
      3'h1: cur_sel = second_sample_input_sel;
      3'h2: cur_sel = third_sample_input_sel;
      3'h3: cur_sel = fourth_sample_input_sel;
      3'h4: cur_sel = fifth_sample_input_sel;
      3'h5: cur_sel = sixth_sample_input_sel;
      3'h6: cur_sel = seventh_sample_input_sel;
      3'h7: cur_sel = eighth_sample_input_sel;
    endcase
  end

  // Request word for the next cycle
  wire logic next_diff = flag_at(differential_sample_flag, pos_d);
  always_comb begin
    req_d = '0;
    req_d.valid = (state_d == ST_CONV);
    req_d.pos = pos_d;
    req_d.sel = cur_sel;
    req_d.diff = next_diff;
    req_d.pin_p = pin_pos(cur_sel, next_diff);
    req_d.pin_n = pin_neg(cur_sel, next_diff);
  end

  wire logic done_d = busy & (state_d == ST_IDLE);

  // Selection register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= SEL_RESET;
    end else begin
      sel_q <= sel_d;
    end
  end

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= CTL_RESET;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Read data is captured on the taking edge and stands unchanged with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else begin
      if (bus_req) begin
        rdat_q <= rdat_d;
      end
    end
  end

  // Acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // Sequencer state and position
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      pos_q <= 3'h0;
    end else begin
      state_q <= state_d;
      pos_q <= pos_d;
    end
  end

  // Conversion request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= '0;
    end else begin
      req_q <= req_d;
    end
  end

  // End-of-sequence pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign conv_req_o = req_q;
  assign seq_done_o = done_q;

endmodule
`default_nettype wire

// ### sim/assi_monitor.sv
// Checker for the sequence input select block
`timescale 1ns/1ps
`default_nettype none
module assi_monitor
  import assi_pkg::*;
(
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o, seq_start_i, conv_done_i, seq_done_o,
  input wire assi_conv_req_s conv_req_o
);
  assi_conv_req_s c;
  assign c = conv_req_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  AST_GAP: assert property (wb_ack_o && !wb_we_i && wb_adr_i == SEL_OFFSET
    |-> (wb_dat_o & ~SEL_WMASK) == 32'h0) else $error("gap bits set");
  AST_SE: assert property (c.valid && !c.diff |-> c.pin_p == {2'h0, c.sel}
    && c.pin_n == 4'h0) else $error("single pin");
  AST_DIFF: assert property (c.valid && c.diff |-> c.pin_p == {1'b0, c.sel, 1'b0}
    && c.pin_n == {1'b0, c.sel, 1'b1}) else $error("pair pins");
  AST_STEP: assert property (c.valid && conv_done_i
    |=> !c.valid || c.pos == $past(c.pos) + 3'h1) else $error("bad step");
  AST_HOLD: assert property (c.valid && !conv_done_i |=> c.valid && $stable(c.pos))
    else $error("pos moved");
  AST_START: assert property (seq_start_i && !c.valid |=> c.valid && c.pos == 3'h0)
    else $error("no start");
  AST_LAST: assert property (c.valid && conv_done_i && c.pos == 3'h7
    |=> !c.valid && seq_done_o) else $error("ran past end");
  cover property (c.valid && c.diff);
  cover property (c.valid && c.pos == 3'h7);
  cover property (seq_done_o);
endmodule
bind assi_top assi_monitor mon (.*);
`default_nettype wire

// ### sim/assi_top_tb.sv
// Self-checking bench for the sequence input select block
`timescale 1ns/1ps
`default_nettype none
module assi_top_tb
  import assi_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, st = 0, dn = 0, ack, done;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, rdat;
  assi_conv_req_s q;
  int miscompares = 0, checks_done = 0;
  assi_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
    .seq_start_i(st), .conv_done_i(dn), .conv_req_o(q), .seq_done_o(done));
  initial forever #5 clk_i = ~clk_i;
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Entered just after a rising edge; holds the request until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(negedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    @(posedge clk_i);
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  // Field n holds n mod 4, so each position expects its own low index bits
  task automatic run(input logic [31:0] ctl, input int last);
    bus(1'b1, CTL_OFFSET, ctl);
    st <= 1'b1;
    @(posedge clk_i) st <= 1'b0;
    for (int n = 0; n <= last; n++) begin
      @(negedge clk_i);
      chk({q.valid, q.pos, q.sel}, {1'b1, 3'(n), 2'(n)});
      chk({q.pin_p, q.pin_n}, ctl[CTL_DIFF_LSB + n] ? {1'b0, 2'(n), 2'b00, 2'(n), 1'b1}
        : {2'b00, 2'(n), 4'h0});
      @(posedge clk_i) dn <= 1'b1;
      @(posedge clk_i) dn <= 1'b0;
    end
    @(negedge clk_i);
    chk({q.valid, done}, 2'b01);
    @(posedge clk_i);
    $display("sequence test ended");
  endtask
  task automatic reg_test;
    bus(1'b0, SEL_OFFSET, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, SEL_OFFSET, 32'hFFFF_FFFF);
    bus(1'b0, SEL_OFFSET, 32'h0);
    chk(rd, 32'h3333_3333);
    $display("register test ended");
  endtask
  // Read-modify-write of the first field keeps every other bit as read
  task automatic rmw_test;
    bus(1'b0, SEL_OFFSET, 32'h0);
    bus(1'b1, SEL_OFFSET, {rd[31:2], 2'b01});
    bus(1'b0, SEL_OFFSET, 32'h0);
    chk(rd, 32'h3333_3331);
    $display("read-modify-write test ended");
  endtask
  task automatic seq_test;
    bus(1'b1, SEL_OFFSET, 32'h3210_3210);
    run(32'h0000_0420, 5);
    run(32'h0000_0000, 7);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    reg_test;
    rmw_test;
    seq_test;
    summarize;
  end
  initial begin
    #20000;
    miscompares++;
    summarize;
  end
endmodule
`default_nettype wire
